// File: pin_io_pkg.sv
// Purpose: Shared constants and types for the timer pin control block.
// Assumes: Registers sit behind a plain strobe port with 8-bit data.
// Notes: Offsets are indexes of the plain register port.
package pin_io_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam logic [3:0] OFF_CH2_A_CTL = 4'h0;
    localparam logic [3:0] OFF_CH3_A_CTL = 4'h1;
    localparam logic [3:0] OFF_CH3_C_CTL = 4'h2;
    localparam logic [3:0] OFF_CH3_MODE = 4'h3;
    localparam logic [3:0] OFF_PIN_STATUS = 4'h4;
    localparam logic [3:0] OFF_CH2_A_LO = 4'h5;
    localparam logic [3:0] OFF_CH2_A_HI = 4'h6;
    localparam logic [3:0] OFF_CH3_A_LO = 4'h7;
    localparam logic [3:0] OFF_CH3_A_HI = 4'h8;
    localparam logic [3:0] OFF_CH3_C_LO = 4'h9;
    localparam logic [3:0] OFF_CH3_C_HI = 4'ha;
    localparam int CTL_LSB = 0;
    localparam int BUF_AC_BIT = 4;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] GREG_RESET = 16'hffff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] ctl;
        logic ctl_written;
        logic suppress;
    } chan_cfg_t;
endpackage : pin_io_pkg

// File: pin_sync.sv
// Purpose: Three-stage synchroniser that reports a pin change once stages two and three agree.
// Assumes: The pin is asynchronous to the clock.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Pin and result.
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    wire agree = (s2_reg == s3_reg);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign level = level_reg;
    assign rise = agree && s3_reg && !level_reg;
    assign fall = agree && !s3_reg && level_reg;
endmodule : pin_sync

// File: pin_channel.sv
// Purpose: One general register with its pin, as output compare or input capture.
// Assumes: The counter runs on the same clock.
// Notes: A write to the control field applies the initial level in the next cycle.
`timescale 1ns/1ps
module pin_channel
    import pin_io_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Configuration.
    input wire chan_cfg_t cfg,
    input wire logic ctl_wr,
    input wire logic greg_wr,
    input wire logic [W-1:0] greg_wdata,
    // Counter and pin.
    input wire logic [W-1:0] counter,
    input wire logic pin_in,
    // Results.
    output logic [W-1:0] greg,
    output logic pin_out,
    output logic pin_oe,
    output logic event_pulse
);
    logic [W-1:0] greg_reg;
    logic [W-1:0] greg_next;
    logic out_reg;
    logic out_next;
    logic evt_reg;
    logic rise;
    logic fall;

    pin_sync u_sync (
        .clock(clock),
        .rst(rst),
        .pin_in(pin_in),
        .level(),
        .rise(rise),
        .fall(fall)
    );

    wire is_capture = cfg.ctl[3];
    wire active = !cfg.suppress;
    wire match = active && !is_capture && (counter == greg_reg);
    wire sel_edge = cfg.ctl[1] ? (rise || fall)
                  : (cfg.ctl[0] ? fall
                  : rise);
    wire capture = active && is_capture && sel_edge;
    wire init_level = cfg.ctl[2];

    always_comb begin
        out_next = out_reg;
        if (ctl_wr && !cfg.ctl[3] && cfg.ctl[1:0] != 2'b00) begin
            out_next = init_level;
        end else if (match) begin
            unique case (cfg.ctl[1:0])
                2'b00: out_next = out_reg;
                2'b01: out_next = 1'b0;
                2'b10: out_next = 1'b1;
                2'b11: out_next = !out_reg;
            endcase
        end
    end

    always_comb begin
        greg_next = greg_reg;
        if (capture) begin
            greg_next = counter;
        end else if (greg_wr) begin
            greg_next = greg_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            greg_reg <= W'(GREG_RESET);
            out_reg <= 1'b0;
            evt_reg <= 1'b0;
        end else begin
            greg_reg <= greg_next;
            out_reg <= out_next;
            evt_reg <= match || capture;
        end
    end

    assign greg = greg_reg;
    assign pin_out = out_reg;
    assign pin_oe = !cfg.ctl[3] || !cfg.ctl_written;
    assign event_pulse = evt_reg;

    a_toggle_on_match: assert property (@(posedge clock) disable iff (rst)
        match && !ctl_wr && cfg.ctl[1:0] == 2'b11 |=> pin_out != $past(pin_out))
        else $error("toggle mode did not invert pin on match");
    a_low_on_match: assert property (@(posedge clock) disable iff (rst)
        match && !ctl_wr && cfg.ctl[1:0] == 2'b01 |=> !pin_out)
        else $error("clear mode did not drive pin low");
    a_high_on_match: assert property (@(posedge clock) disable iff (rst)
        match && !ctl_wr && cfg.ctl[1:0] == 2'b10 |=> pin_out)
        else $error("set mode did not drive pin high");
    a_hold_on_match: assert property (@(posedge clock) disable iff (rst)
        match && !ctl_wr && cfg.ctl[1:0] == 2'b00 |=> $stable(pin_out))
        else $error("hold mode changed the pin");
    a_capture_value: assert property (@(posedge clock) disable iff (rst)
        capture |=> greg == $past(counter))
        else $error("capture did not store the counter");
    a_rise_capture: assert property (@(posedge clock) disable iff (rst)
        cfg.ctl[3] && cfg.ctl[1:0] == 2'b00 && fall && !greg_wr |=> $stable(greg))
        else $error("rising mode captured on a falling edge");
    a_fall_capture: assert property (@(posedge clock) disable iff (rst)
        active && cfg.ctl[3] && cfg.ctl[1:0] == 2'b01 && fall |=> evt_reg)
        else $error("falling mode missed a falling edge");
    a_both_capture: assert property (@(posedge clock) disable iff (rst)
        active && cfg.ctl[3] && cfg.ctl[1] && (rise || fall) |=> evt_reg)
        else $error("both-edge mode missed an edge");
    a_suppress_quiet: assert property (@(posedge clock) disable iff (rst)
        cfg.suppress |=> !evt_reg)
        else $error("suppressed register raised an event");
    c_toggle: cover property (@(posedge clock) match && cfg.ctl[1:0] == 2'b11);
    c_capture: cover property (@(posedge clock) capture);
    c_both: cover property (@(posedge clock) capture && cfg.ctl[1]);
endmodule : pin_channel

// File: timer_io_pin_control_ch2_ch3.sv
// Purpose: Pin control of channel 2 register A and channel 3 registers A and C.
// Assumes: Counters come from the surrounding timer on the same clock.
// Notes: Read data appear in the cycle after the read strobe.
// Contract
// - Codes 0000 and 0100 compare but keep the pin level on match.
// - After reset the pin is driven low until its field is written.
// - Code 0001 starts low, 0101 starts high; match drives low.
// - Code 0010 starts low, 0110 starts high; match drives high.
// - Code 0011 starts low, 0111 starts high; match toggles the pin.
// - Bit 3 set, bits 1:0 00 captures on rising edges.
// - Bit 3 set, bits 1:0 01 captures on falling edges.
// - Bit 3 set, bit 1 set captures on both edges.
// - Buffer mode for register C disables its compare and capture.
`timescale 1ns/1ps
module timer_io_pin_control_ch2_ch3
    import pin_io_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Register port.
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Counters.
    input wire logic [W-1:0] ch2_count,
    input wire logic [W-1:0] ch3_count,
    // Pins.
    input wire logic ch2_pin_a_in,
    output logic ch2_pin_a_out,
    output logic ch2_pin_a_oe,
    input wire logic ch3_pin_a_in,
    output logic ch3_pin_a_out,
    output logic ch3_pin_a_oe,
    input wire logic ch3_pin_c_in,
    output logic ch3_pin_c_out,
    output logic ch3_pin_c_oe,
    // Events.
    output logic [2:0] event_out
);
    if (W != 16) begin : g_width_check
        $error("only a 16-bit register width is served");
    end

    logic [7:0] ch2_pin_a_io_control_reg;
    logic [7:0] ch3_pin_a_io_control_reg;
    logic [7:0] ch3_pin_c_io_control_reg;
    logic [7:0] ch3_mode_reg;
    logic [2:0] written_reg;
    logic [2:0] ctl_wr_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [2:0] pin_out_w;
    logic [2:0] pin_oe_w;
    logic [2:0] evt_w;
    logic [2:0] pout_reg;
    logic [2:0] poe_reg;
    logic [2:0] evt_reg;
    logic [W-1:0] greg_w [3];
    logic [W-1:0] wr_word [3];
    logic [2:0] greg_wr;

    reg_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    wire wr_ctl2a = req.wr && req.addr == OFF_CH2_A_CTL;
    wire wr_ctl3a = req.wr && req.addr == OFF_CH3_A_CTL;
    wire wr_ctl3c = req.wr && req.addr == OFF_CH3_C_CTL;
    wire wr_mode = req.wr && req.addr == OFF_CH3_MODE;
    wire buf_c = ch3_mode_reg[BUF_AC_BIT];

    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [7:0] b,
                                           input logic hi);
        merge = hi ? {b, old[7:0]} : {old[W-1:8], b};
    endfunction : merge

    assign greg_wr[0] = req.wr && (req.addr == OFF_CH2_A_LO || req.addr == OFF_CH2_A_HI);
    assign greg_wr[1] = req.wr && (req.addr == OFF_CH3_A_LO || req.addr == OFF_CH3_A_HI);
    assign greg_wr[2] = req.wr && (req.addr == OFF_CH3_C_LO || req.addr == OFF_CH3_C_HI);
    assign wr_word[0] = merge(greg_w[0], req.wdata, req.addr == OFF_CH2_A_HI);
    assign wr_word[1] = merge(greg_w[1], req.wdata, req.addr == OFF_CH3_A_HI);
    assign wr_word[2] = merge(greg_w[2], req.wdata, req.addr == OFF_CH3_C_HI);

    chan_cfg_t cfg [3];
    assign cfg[0] = '{ctl: ch2_pin_a_io_control_reg[CTL_LSB +: 4], ctl_written: written_reg[0],
                      suppress: 1'b0};
    assign cfg[1] = '{ctl: ch3_pin_a_io_control_reg[CTL_LSB +: 4], ctl_written: written_reg[1],
                      suppress: 1'b0};
    assign cfg[2] = '{ctl: ch3_pin_c_io_control_reg[CTL_LSB +: 4], ctl_written: written_reg[2],
                      suppress: buf_c};

    wire [W-1:0] cnt_sel [3] = '{ch2_count, ch3_count, ch3_count};
    wire [2:0] pin_in_w = {ch3_pin_c_in, ch3_pin_a_in, ch2_pin_a_in};

    for (genvar i = 0; i < 3; i++) begin : g_ch
        pin_channel #(.W(W)) u_ch (
            .clock(clock),
            .rst(rst),
            .cfg(cfg[i]),
            .ctl_wr(ctl_wr_reg[i]),
            .greg_wr(greg_wr[i]),
            .greg_wdata(wr_word[i]),
            .counter(cnt_sel[i]),
            .pin_in(pin_in_w[i]),
            .greg(greg_w[i]),
            .pin_out(pin_out_w[i]),
            .pin_oe(pin_oe_w[i]),
            .event_pulse(evt_w[i])
        );
    end

    always_comb begin
        unique case (req.addr)
            OFF_CH2_A_CTL: rdata_next = ch2_pin_a_io_control_reg;
            OFF_CH3_A_CTL: rdata_next = ch3_pin_a_io_control_reg;
            OFF_CH3_C_CTL: rdata_next = ch3_pin_c_io_control_reg;
            OFF_CH3_MODE: rdata_next = ch3_mode_reg;
            OFF_PIN_STATUS: rdata_next = {2'b00, pin_oe_w, pin_out_w};
            OFF_CH2_A_LO: rdata_next = greg_w[0][7:0];
            OFF_CH2_A_HI: rdata_next = greg_w[0][15:8];
            OFF_CH3_A_LO: rdata_next = greg_w[1][7:0];
            OFF_CH3_A_HI: rdata_next = greg_w[1][15:8];
            OFF_CH3_C_LO: rdata_next = greg_w[2][7:0];
            OFF_CH3_C_HI: rdata_next = greg_w[2][15:8];
            default: rdata_next = READ_UNMAPPED;
        endcase
        if (!req.rd) begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ch2_pin_a_io_control_reg <= CTL_RESET;
            ch3_pin_a_io_control_reg <= CTL_RESET;
            ch3_pin_c_io_control_reg <= CTL_RESET;
            ch3_mode_reg <= MODE_RESET;
            written_reg <= 3'h0;
            ctl_wr_reg <= 3'h0;
            rdata_reg <= 8'h00;
        end else begin
            if (wr_ctl2a) ch2_pin_a_io_control_reg <= req.wdata;
            if (wr_ctl3a) ch3_pin_a_io_control_reg <= req.wdata;
            if (wr_ctl3c) ch3_pin_c_io_control_reg <= req.wdata;
            if (wr_mode) ch3_mode_reg <= req.wdata;
            written_reg <= written_reg | {wr_ctl3c, wr_ctl3a, wr_ctl2a};
            ctl_wr_reg <= {wr_ctl3c, wr_ctl3a, wr_ctl2a};
            rdata_reg <= rdata_next;
        end
    end

    // Pins stay low and driven until their field is first written.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pout_reg <= 3'h0;
            poe_reg <= 3'h7;
            evt_reg <= 3'h0;
        end else begin
            pout_reg <= pin_out_w & written_reg;
            poe_reg <= pin_oe_w | ~written_reg;
            evt_reg <= evt_w;
        end
    end

    assign rdata = rdata_reg;
    assign {ch3_pin_c_out, ch3_pin_a_out, ch2_pin_a_out} = pout_reg;
    assign {ch3_pin_c_oe, ch3_pin_a_oe, ch2_pin_a_oe} = poe_reg;
    assign event_out = evt_reg;

    a_low_before_write: assert property (@(posedge clock) disable iff (rst)
        !written_reg[0] |=> !ch2_pin_a_out && ch2_pin_a_oe)
        else $error("pin not low before its field was written");
    a_buffer_no_event: assert property (@(posedge clock) disable iff (rst)
        buf_c ##1 buf_c |=> !event_out[2])
        else $error("buffered register C raised an event");
    a_ch3a_low_start: assert property (@(posedge clock) disable iff (rst)
        !written_reg[1] |=> !ch3_pin_a_out && ch3_pin_a_oe)
        else $error("ch3 pin a not low before its field was written");
    a_ch3c_low_start: assert property (@(posedge clock) disable iff (rst)
        !written_reg[2] |=> !ch3_pin_c_out && ch3_pin_c_oe)
        else $error("ch3 pin c not low before its field was written");
    a_capture_releases: assert property (@(posedge clock) disable iff (rst)
        written_reg[0] && ch2_pin_a_io_control_reg[3] |=> !ch2_pin_a_oe)
        else $error("capture mode still drives the pin");
    a_compare_drives: assert property (@(posedge clock) disable iff (rst)
        written_reg[0] && !ch2_pin_a_io_control_reg[3] |=> ch2_pin_a_oe)
        else $error("compare mode does not drive the pin");
    a_read_idle_zero: assert property (@(posedge clock) disable iff (rst)
        !rd |=> rdata == 8'h00)
        else $error("read data stood outside its cycle");
    c_buffer_mode: cover property (@(posedge clock) buf_c && ch3_pin_c_io_control_reg[3]);
    c_first_write: cover property (@(posedge clock) wr_ctl2a && !written_reg[0]);
endmodule : timer_io_pin_control_ch2_ch3

// File: pin_partner.sv
// Purpose: Outside circuits on the three timer pins.
// Assumes: The bench sets the level that outside circuits present.
// Notes: A pin that the block drives reads back the block's own level.
`timescale 1ns/1ps
module pin_partner (
    // Block side.
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    // Outside level and resolved wire.
    input wire logic [2:0] ext_level,
    output logic [2:0] wire_level
);
    // Each wire follows whichever party drives it.
    assign wire_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_partner

// File: test_timer_io_pin_control_ch2_ch3.sv
// Purpose: Self-checking bench for the timer pin control block.
// Assumes: Registers are reached through the strobe port.
// Notes: Channel index 0 is ch2 A, 1 is ch3 A, 2 is ch3 C.
`timescale 1ns/1ps
module test_timer_io_pin_control_ch2_ch3;
    import pin_io_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [15:0] ch2_count = 16'h0000;
    logic [15:0] ch3_count = 16'h0000;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [2:0] ext_level = 3'h0;
    logic [2:0] wire_level;
    logic [2:0] event_out;
    int mismatches = 0;
    int check_count = 0;
    logic [3:0] ctl_off [3] = '{OFF_CH2_A_CTL, OFF_CH3_A_CTL, OFF_CH3_C_CTL};
    logic [3:0] lo_off [3] = '{OFF_CH2_A_LO, OFF_CH3_A_LO, OFF_CH3_C_LO};
    logic [15:0] exp_greg [3];
    logic [2:0] exp_pin = 3'h0;

    timer_io_pin_control_ch2_ch3 i_timer_io_pin_control_ch2_ch3 (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ch2_count(ch2_count), .ch3_count(ch3_count),
        .ch2_pin_a_in(wire_level[0]), .ch2_pin_a_out(pin_out[0]), .ch2_pin_a_oe(pin_oe[0]),
        .ch3_pin_a_in(wire_level[1]), .ch3_pin_a_out(pin_out[1]), .ch3_pin_a_oe(pin_oe[1]),
        .ch3_pin_c_in(wire_level[2]), .ch3_pin_c_out(pin_out[2]), .ch3_pin_c_oe(pin_oe[2]),
        .event_out(event_out)
    );

    pin_partner i_pin_partner (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .wire_level(wire_level)
    );

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : read_reg

    task automatic read_greg(input int ch, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        read_reg(lo_off[ch], lo);
        read_reg(lo_off[ch] + 4'h1, hi);
        v = {hi, lo};
    endtask : read_greg

    task automatic set_count(input int ch, input logic [15:0] v);
        if (ch == 0) begin
            ch2_count <= v;
        end else begin
            ch3_count <= v;
        end
    endtask : set_count

    // Holds the counter on the register value for one cycle and watches the event.
    task automatic match(input int ch, input logic [15:0] v, output logic ev);
        ev = 1'b0;
        @(posedge clock);
        set_count(ch, v);
        @(posedge clock);
        set_count(ch, 16'h0000);
        repeat (5) begin
            @(posedge clock);
            #1 ev = ev | event_out[ch];
        end
    endtask : match

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        logic ev;
        logic [7:0] d;
        logic [15:0] g;
        logic [3:0] code;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        tick(1);
        check(16'({pin_oe, pin_out}), 16'h0038, "reset pins");
        for (int ch = 0; ch < 3; ch++) begin
            read_reg(ctl_off[ch], d);
            check(16'(d), 16'(CTL_RESET), "reset control");
            read_greg(ch, g);
            check(g, GREG_RESET, "reset general register");
        end
        read_reg(OFF_PIN_STATUS, d);
        check(16'(d), 16'h0038, "status");
        read_reg(4'hb, d);
        check(16'(d), 16'(READ_UNMAPPED), "unmapped read");
        $display("test reset done");
        for (int ch = 0; ch < 3; ch++) begin
            exp_greg[ch] = 16'h0101 * 16'(ch + 1);
            write_reg(lo_off[ch], exp_greg[ch][7:0]);
            write_reg(lo_off[ch] + 4'h1, exp_greg[ch][15:8]);
            for (int c = 0; c < 8; c++) begin
                code = 4'(c);
                write_reg(ctl_off[ch], {4'h0, code});
                tick(3);
                if (code[1:0] != 2'b00) exp_pin[ch] = code[2];
                check(16'(pin_out[ch]), 16'(exp_pin[ch]), "start level");
                match(ch, exp_greg[ch], ev);
                case (code[1:0])
                    2'b01: exp_pin[ch] = 1'b0;
                    2'b10: exp_pin[ch] = 1'b1;
                    2'b11: exp_pin[ch] = ~exp_pin[ch];
                    default: ;
                endcase
                check(16'(pin_out[ch]), 16'(exp_pin[ch]), "match level");
                check(16'({ev, pin_oe[ch]}), 16'h0003, "match event");
            end
        end
        $display("test compare done");
        for (int ch = 0; ch < 3; ch++) begin
            for (int k = 0; k < 8; k++) begin
                code = 4'(k + 8);
                @(posedge clock);
                ext_level[ch] <= exp_pin[ch];
                write_reg(ctl_off[ch], {4'h0, code});
                tick(3);
                check(16'(pin_oe[ch]), 16'h0000, "capture releases pin");
                for (int e = 0; e < 3; e++) begin
                    g = 16'h1000 + 16'(ch * 256 + k * 16 + e);
                    @(posedge clock);
                    set_count(ch, g);
                    ext_level[ch] <= ~exp_pin[ch];
                    tick(8);
                    exp_pin[ch] = ~exp_pin[ch];
                    if (code[1] || (code[0] != exp_pin[ch])) exp_greg[ch] = g;
                    read_greg(ch, g);
                    check(g, exp_greg[ch], "capture");
                end
            end
        end
        $display("test capture done");
        @(posedge clock);
        set_count(2, 16'h0000);
        write_reg(OFF_CH3_C_CTL, 8'h05);
        tick(3);
        check(16'(pin_out[2]), 16'h0001, "start high");
        write_reg(OFF_CH3_MODE, 8'h10);
        read_reg(OFF_CH3_MODE, d);
        check(16'(d), 16'h0010, "mode readback");
        match(2, exp_greg[2], ev);
        check(16'({ev, pin_out[2]}), 16'h0001, "buffer suppresses");
        write_reg(OFF_CH3_MODE, 8'h00);
        match(2, exp_greg[2], ev);
        check(16'({ev, pin_out[2]}), 16'h0002, "buffer off");
        $display("test buffer done");
        complete_run();
    end
endmodule : test_timer_io_pin_control_ch2_ch3
